// ==== core/eprvp_regs.svh ====
// Offsets, field positions, reset values and pin patterns of the port
`ifndef EPRVP_REGS_SVH
`define EPRVP_REGS_SVH

// Register byte offsets
`define EPRVP_OFF_CTRL     12'h000
`define EPRVP_OFF_STATUS   12'h004
`define EPRVP_OFF_LASTADR  12'h008

// Control fields and reset value
`define EPRVP_CTRL_ERASE   0
`define EPRVP_CTRL_PORTEN  1
`define EPRVP_CTRL_RESET   1'h1

// Status fields
`define EPRVP_ST_MODE_LO   0
`define EPRVP_ST_MODE_HI   2
`define EPRVP_ST_BUSY      3
`define EPRVP_ST_CNT_LO    8
`define EPRVP_ST_CNT_HI    15

// Control-line patterns, ordered p2.6 p2.7 p3.3 p3.6 p3.7
`define EPRVP_PAT_PROG     5'h0F
`define EPRVP_PAT_VERIFY   5'h03
`define EPRVP_PAT_CRYPT    5'h0D
`define EPRVP_PAT_LOCK1    5'h1F
`define EPRVP_PAT_LOCK2    5'h1C
`define EPRVP_PAT_LOCK3    5'h16
`define EPRVP_PAT_SIG      5'h00

// Signature locations
`define EPRVP_SIG_ADR0     14'h0030
`define EPRVP_SIG_ADR1     14'h0031
`define EPRVP_SIG_ADR2     14'h0060

// Array geometry and fill values
`define EPRVP_CRYPT_AW     6
`define EPRVP_BLANK        8'hFF
`define EPRVP_LOCKED_DATA  8'hFF

`endif

// ==== core/eprvp_pkg.sv ====
// Types shared by the program and verify port
package eprvp_pkg;

  // Operation selected by the control lines
  typedef enum logic [2:0] {
    EPRVP_IDLE   = 3'b000,
    EPRVP_PROG   = 3'b001,
    EPRVP_VERIFY = 3'b010,
    EPRVP_CRYPT  = 3'b011,
    EPRVP_LOCK1  = 3'b100,
    EPRVP_LOCK2  = 3'b101,
    EPRVP_LOCK3  = 3'b110,
    EPRVP_SIG    = 3'b111
  } eprvp_mode_t;

endpackage

// ==== core/eprvp_mem.sv ====
// Byte array with programming (bitwise AND) writes and registered read
`timescale 1ns/1ps
module eprvp_mem #(
  parameter int AW = 14
) (
  // Clock
  input  wire logic          clk,
  // Access
  input  wire logic [AW-1:0] addr,
  input  wire logic          we,
  input  wire logic          and_mode,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [0:(2**AW)-1];

  // Programming can only clear bits; erase writes plain data
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= and_mode ? (mem[addr] & wdata) : wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk) begin
    rdata <= mem[addr];
  end

endmodule // eprvp_mem

// ==== core/eprvp_port.sv ====
// Program and verify port of the on-chip EPROM with lock system
//
// Behaviour
// - With reset high and fetch strobe low, five control lines choose operation.
// - Verify and signature read need strobe and voltage pin held high; here strobe and access pin high with program_voltage_present low.
// - Address bits come from port1, port2 lines 0-5 and port3 lines 4-5.
// - Data bits travel on port0, driven by programmer or by device.
// - Lock bits have no direct readout, only their protection effects.
// - Three cumulative lock bits plus a 64-byte encryption array.
// - Erasure clears the array, encryption table and all lock bits.
// - Verify returns code XNOR encryption byte picked by six address bits.
// - Lock one blocks table reads, latches access pin, stops programming; two together with one stops verify.
// - All three lock bits also disable external execution.
// - Signature read returns bytes at 30H, 31H and 60H like verify.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "eprvp_regs.svh"
module eprvp_port #(
  parameter int         AW   = 14,
  parameter logic [7:0] SIG0 = 8'hA5,  // Arbitrary identity value
  parameter logic [7:0] SIG1 = 8'h5A,  // Arbitrary identity value
  parameter logic [7:0] SIG2 = 8'h3C   // Arbitrary identity value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Control pins
  input  wire logic        reset_pin,
  input  wire logic        program_fetch_strobe_n,
  input  wire logic        latch_strobe_program_pulse,
  input  wire logic        external_access_program_voltage,
  input  wire logic        program_voltage_present,
  input  wire logic        port2_line6_control,
  input  wire logic        port2_line7_control,
  input  wire logic        port3_line3_control,
  input  wire logic        port3_line6_control,
  input  wire logic        port3_line7_control,
  // Address and data pins
  input  wire logic [7:0]  port1_in,
  input  wire logic [5:0]  port2_in,
  input  wire logic [1:0]  port3_addr_in,
  input  wire logic [7:0]  port0_in,
  output logic      [7:0]  port0_out,
  output logic             port0_oe,
  // Protection effects towards the core
  output logic             table_read_block,
  output logic             ea_latch_active,
  output logic             ea_latched,
  output logic             ext_exec_block
);

  localparam int PIN_W = 34;

  // Synchronised pins
  logic [PIN_W-1:0] pin_raw, pin_s1, pin_s2;
  logic s_rst, s_program_fetch_strobe_n_n, s_prog, s_ea, s_vpp;
  logic [4:0] s_pat;
  logic [1:0] s_p3a;
  logic [5:0] s_p2a;
  logic [7:0] s_p1a, s_data;
  logic [AW-1:0] s_addr, addr_q;
  logic [13:0] pin_addr;

  // State
  eprvp_pkg::eprvp_mode_t mode, next_mode;
  logic prog_d, rst_d, strobe_fall, accept;
  logic lock_one, lock_two, lock_three;
  logic erasing, port_en;
  logic [AW-1:0] erase_cnt, last_addr;
  logic [7:0] pulse_cnt;
  logic code_prog, crypt_prog;
  logic [7:0] code_rd, crypt_rd;
  logic apb_done, apb_hit;
  logic [31:0] rd_mux;

  assign pin_raw = {reset_pin, program_fetch_strobe_n,
                    latch_strobe_program_pulse,
                    external_access_program_voltage, program_voltage_present,
                    port2_line6_control, port2_line7_control,
                    port3_line3_control, port3_line6_control,
                    port3_line7_control, port3_addr_in, port2_in,
                    port1_in, port0_in};

  // Two-flop synchroniser per pin, all pins are asynchronous here
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge clk) begin
      pin_s1[i] <= pin_raw[i];
      pin_s2[i] <= pin_s1[i];
    end
  end

  assign {s_rst, s_program_fetch_strobe_n_n, s_prog, s_ea, s_vpp, s_pat, s_p3a, s_p2a,
          s_p1a, s_data} = pin_s2;

  // Upper bits appear on both ports; either may carry them
  assign pin_addr = {s_p2a[5:4] | s_p3a, s_p2a[3:0], s_p1a};
  // A smaller array ignores the upper pin bits on purpose
  assign s_addr = pin_addr[AW-1:0];

  // Operation decode from the control-line pattern
  always_comb begin
    next_mode = eprvp_pkg::EPRVP_IDLE;
    if (s_rst && !s_program_fetch_strobe_n_n) begin
      unique case (s_pat)
        `EPRVP_PAT_PROG:   next_mode = eprvp_pkg::EPRVP_PROG;
        `EPRVP_PAT_CRYPT:  next_mode = eprvp_pkg::EPRVP_CRYPT;
        `EPRVP_PAT_LOCK1:  next_mode = eprvp_pkg::EPRVP_LOCK1;
        `EPRVP_PAT_LOCK2:  next_mode = eprvp_pkg::EPRVP_LOCK2;
        `EPRVP_PAT_LOCK3:  next_mode = eprvp_pkg::EPRVP_LOCK3;
        `EPRVP_PAT_VERIFY: if (s_prog && s_ea && !s_vpp) begin
          next_mode = eprvp_pkg::EPRVP_VERIFY;
        end
        `EPRVP_PAT_SIG:    if (s_prog && s_ea && !s_vpp) begin
          next_mode = eprvp_pkg::EPRVP_SIG;
        end
        default:           next_mode = eprvp_pkg::EPRVP_IDLE;
      endcase
    end
  end

  // Mode and aligned address registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode   <= eprvp_pkg::EPRVP_IDLE;
      addr_q <= '0;
      prog_d <= 1'b1;
      rst_d  <= 1'b0;
    end else begin
      mode   <= next_mode;
      addr_q <= s_addr;
      prog_d <= s_prog;
      rst_d  <= s_rst;
    end
  end

  // A pulse counts only with voltage applied in a programming mode
  assign strobe_fall = prog_d && !s_prog;
  assign accept = strobe_fall && s_vpp && !erasing
                  && mode != eprvp_pkg::EPRVP_IDLE
                  && mode != eprvp_pkg::EPRVP_VERIFY
                  && mode != eprvp_pkg::EPRVP_SIG;
  assign code_prog  = accept && mode == eprvp_pkg::EPRVP_PROG
                      && !lock_one;
  assign crypt_prog = accept && mode == eprvp_pkg::EPRVP_CRYPT
                      && !lock_one;

  // Code array; programming ANDs so repeated pulses are harmless
  eprvp_mem #(.AW(AW)) u_code (
    .clk      (clk),
    .addr     (erasing ? erase_cnt : s_addr),
    .we       (erasing || code_prog),
    .and_mode (!erasing),
    .wdata    (erasing ? `EPRVP_BLANK : s_data),
    .rdata    (code_rd)
  );

  // Encryption table selected by the low six address bits
  eprvp_mem #(.AW(`EPRVP_CRYPT_AW)) u_crypt (
    .clk      (clk),
    .addr     (erasing ? erase_cnt[`EPRVP_CRYPT_AW-1:0]
                       : s_addr[`EPRVP_CRYPT_AW-1:0]),
    .we       ((erasing && erase_cnt < AW'(2**`EPRVP_CRYPT_AW))
               || crypt_prog),
    .and_mode (!erasing),
    .wdata    (erasing ? `EPRVP_BLANK : s_data),
    .rdata    (crypt_rd)
  );

  // Lock bits: set by pulses, cleared by erase or by reset
  always_ff @(posedge clk) begin
    if (!rst_n || erasing) begin
      lock_one   <= 1'b0;
      lock_two   <= 1'b0;
      lock_three <= 1'b0;
    end else if (accept) begin
      if (mode == eprvp_pkg::EPRVP_LOCK1) lock_one   <= 1'b1;
      if (mode == eprvp_pkg::EPRVP_LOCK2) lock_two   <= 1'b1;
      if (mode == eprvp_pkg::EPRVP_LOCK3) lock_three <= 1'b1;
    end
  end

  // Erase sweeps every location back to blank
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      erasing   <= 1'b0;
      erase_cnt <= '0;
    end else if (erasing) begin
      erase_cnt <= erase_cnt + AW'(1);
      if (&erase_cnt) erasing <= 1'b0;
    end else if (apb_done && pwrite && paddr == `EPRVP_OFF_CTRL
                 && pwdata[`EPRVP_CTRL_ERASE]) begin
      erasing   <= 1'b1;
      erase_cnt <= '0;
    end
  end

  // Pulse count per location, restarted when the address moves
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_cnt <= '0;
      last_addr <= '0;
    end else if (accept) begin
      last_addr <= s_addr;
      pulse_cnt <= (s_addr == last_addr) ? pulse_cnt + 8'h01 : 8'h01;
    end
  end

  // Data port drive; only reads turn the driver on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port0_oe  <= 1'b0;
      port0_out <= '0;
    end else begin
      port0_oe <= port_en && !erasing
                  && (mode == eprvp_pkg::EPRVP_VERIFY
                      || mode == eprvp_pkg::EPRVP_SIG);
      if (mode == eprvp_pkg::EPRVP_SIG) begin
        unique case (addr_q)
          AW'(`EPRVP_SIG_ADR0): port0_out <= SIG0;
          AW'(`EPRVP_SIG_ADR1): port0_out <= SIG1;
          AW'(`EPRVP_SIG_ADR2): port0_out <= SIG2;
          default:         port0_out <= `EPRVP_BLANK;
        endcase
      end else if (lock_one && lock_two) begin
        port0_out <= `EPRVP_LOCKED_DATA;
      end else begin
        port0_out <= ~(code_rd ^ crypt_rd);
      end
    end
  end

  // Protection effects; the lock bits themselves are never readable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      table_read_block <= 1'b0;
      ea_latch_active  <= 1'b0;
      ext_exec_block   <= 1'b0;
      ea_latched       <= 1'b0;
    end else begin
      table_read_block <= lock_one;
      ea_latch_active  <= lock_one;
      ext_exec_block   <= lock_one && lock_two && lock_three;
      if (lock_one && rst_d && !s_rst) ea_latched <= s_ea;
    end
  end

  // APB: one wait state, write lands on the edge that samples pready
  assign apb_done = psel && penable && pready;
  assign apb_hit  = paddr == `EPRVP_OFF_CTRL || paddr == `EPRVP_OFF_STATUS
                    || paddr == `EPRVP_OFF_LASTADR;

  // Read mux; no field exposes a lock bit
  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      `EPRVP_OFF_CTRL: rd_mux[`EPRVP_CTRL_PORTEN] = port_en;
      `EPRVP_OFF_STATUS: begin
        rd_mux[`EPRVP_ST_MODE_HI:`EPRVP_ST_MODE_LO] = mode;
        rd_mux[`EPRVP_ST_BUSY] = erasing;
        rd_mux[`EPRVP_ST_CNT_HI:`EPRVP_ST_CNT_LO]   = pulse_cnt;
      end
      `EPRVP_OFF_LASTADR: rd_mux[AW-1:0] = last_addr;
      default: rd_mux = '0;
    endcase
  end

  // Bus handshake and answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !apb_hit;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_en <= `EPRVP_CTRL_RESET;
    end else if (apb_done && pwrite && paddr == `EPRVP_OFF_CTRL) begin
      port_en <= pwdata[`EPRVP_CTRL_PORTEN];
    end
  end

  // Checks
  sequence seq_sig_hold;
    mode == eprvp_pkg::EPRVP_SIG && addr_q == AW'(`EPRVP_SIG_ADR0)
    && !erasing;
  endsequence

  sequence seq_locked_verify;
    mode == eprvp_pkg::EPRVP_VERIFY && lock_one && lock_two;
  endsequence

  AST_OE_ONLY_READ: assert property (@(posedge clk) disable iff (!rst_n)
    port0_oe |-> $past(mode) == eprvp_pkg::EPRVP_VERIFY
                 || $past(mode) == eprvp_pkg::EPRVP_SIG)
    else $error("data port driven outside a read");

  AST_NO_OE_PROG: assert property (@(posedge clk) disable iff (!rst_n)
    mode == eprvp_pkg::EPRVP_PROG |=> !port0_oe)
    else $error("data port driven during programming");

  AST_NO_VPP_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    strobe_fall && !s_vpp && !erasing |=> $stable(lock_one)
      && $stable(lock_two) && $stable(lock_three))
    else $error("lock state changed without programming voltage");

  AST_LOCK_NO_PROG: assert property (@(posedge clk) disable iff (!rst_n)
    lock_one |-> !code_prog && !crypt_prog)
    else $error("programming accepted while locked");

  AST_LOCK_NO_VERIFY: assert property (@(posedge clk) disable iff (!rst_n)
    seq_locked_verify ##1 seq_locked_verify |->
      port0_out == `EPRVP_LOCKED_DATA)
    else $error("verify returned data while locked");

  AST_LOCK_EXT_EXEC: assert property (@(posedge clk) disable iff (!rst_n)
    lock_one && lock_two && lock_three |-> ##1 ext_exec_block)
    else $error("external execution not blocked");

  AST_TABLE_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(lock_one) |=> table_read_block && ea_latch_active)
    else $error("table reads not blocked after lock");

  AST_ERASE_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(erasing) |-> !lock_one && !lock_two && !lock_three)
    else $error("erase left a lock bit set");

  AST_SIG_BYTE: assert property (@(posedge clk) disable iff (!rst_n)
    seq_sig_hold |=> port0_out == SIG0)
    else $error("wrong signature byte");

  AST_MODE_DECODE: assert property (@(posedge clk) disable iff (!rst_n)
    s_rst && !s_program_fetch_strobe_n_n && s_pat == `EPRVP_PAT_LOCK2 |=>
      mode == eprvp_pkg::EPRVP_LOCK2)
    else $error("control pattern decoded wrongly");

endmodule // eprvp_port

// ==== dv/eprvp_prog_model.sv ====
// Programmer model driving the pin side of the port
`timescale 1ns/1ps
module eprvp_prog_model (
  // Clock
  input  wire logic        clk,
  // Device read-back
  input  wire logic [7:0]  rd,
  input  wire logic        drv,
  // Pins towards the device
  output logic             rpin,
  output logic             fetch_n,
  output logic             pgm_n,
  output logic             acc,
  output logic             volt,
  output logic      [4:0]  pat,
  output logic      [13:0] adr,
  output logic      [7:0]  dat
);
  // Idle pin levels: device held in reset, fetch strobe low
  initial begin
    rpin    = 1'b1;
    fetch_n = 1'b0;
    pgm_n   = 1'b1;
    acc     = 1'b1;
    volt    = 1'b0;
    pat     = 5'h03;
    adr     = 14'h0000;
    dat     = 8'h00;
  end

  // Address, data and pattern first, then voltage, then strobes
  task automatic prog(input logic [4:0] p, input logic [13:0] a,
                      input logic [7:0] d, input int n, input logic v);
    @(posedge clk);
    adr <= a;
    dat <= d;
    pat <= p;
    repeat (4) @(posedge clk);
    volt <= v;
    repeat (2) @(posedge clk);
    repeat (n) begin
      pgm_n <= 1'b0;
      repeat (3) @(posedge clk);
      pgm_n <= 1'b1;
      repeat (3) @(posedge clk);
    end
    volt <= 1'b0;
    @(posedge clk);
  endtask

  // Drop and raise the reset pin; access pin stays high throughout
  task automatic pulse_reset;
    @(posedge clk);
    rpin <= 1'b0;
    repeat (4) @(posedge clk);
    rpin <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // Read with strobe and access pin high; data lines let go
  task automatic rd_byte(input logic [4:0] p, input logic [13:0] a,
                         output logic [7:0] d, output logic oe);
    @(posedge clk);
    adr <= a;
    pat <= p;
    dat <= ~dat;  // Released lines must not show a stale byte
    repeat (6) @(posedge clk);
    d = rd;
    oe = drv;
  endtask
endmodule  // eprvp_prog_model

// ==== dv/eprvp_port_tb.sv ====
// Self-checking bench of the program and verify port
`timescale 1ns/1ps
`include "eprvp_regs.svh"
module eprvp_port_tb;
  localparam logic [7:0] SIG0 = 8'hA5;  // Arbitrary identity value
  localparam logic [7:0] SIG1 = 8'h5A;  // Arbitrary identity value
  localparam logic [7:0] SIG2 = 8'h3C;  // Arbitrary identity value
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic        rpin, fetch_n, pgm_n, acc, volt, oe, e;
  logic [4:0]  pat;
  logic [13:0] adr, a;
  logic [7:0]  dat, p0_out, p0_in, d;
  logic        trb, eaa, eal, xeb;
  logic [7:0]  mem [256];
  logic [7:0]  tab [64];
  logic [2:0]  lk;
  int          err_total, n_compared, cyc, i;

  // Bus wire: device drives while enabled, else the programmer
  assign p0_in = oe ? p0_out : dat;

  eprvp_port #(.AW(8), .SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2))
  eprvp_port_i (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_pin(rpin),
    .program_fetch_strobe_n(fetch_n), .latch_strobe_program_pulse(pgm_n),
    .external_access_program_voltage(acc),
    .program_voltage_present(volt), .port2_line6_control(pat[4]),
    .port2_line7_control(pat[3]), .port3_line3_control(pat[2]),
    .port3_line6_control(pat[1]), .port3_line7_control(pat[0]),
    .port1_in(adr[7:0]), .port2_in(adr[13:8]),
    .port3_addr_in(adr[13:12]), .port0_in(p0_in), .port0_out(p0_out),
    .port0_oe(oe), .table_read_block(trb), .ea_latch_active(eaa),
    .ea_latched(eal), .ext_exec_block(xeb));

  eprvp_prog_model eprvp_prog_model_i (.clk(clk), .rd(p0_out),
    .drv(oe), .rpin(rpin), .fetch_n(fetch_n), .pgm_n(pgm_n), .acc(acc),
    .volt(volt), .pat(pat), .adr(adr), .dat(dat));

  // Clock and hang guard; device clock stays steady all run
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Expected read-back; signature is never encrypted or locked
  function automatic logic [7:0] exp_rd(input logic [4:0] p,
                                        input logic [13:0] x);
    if (p == `EPRVP_PAT_SIG) begin
      if (x == `EPRVP_SIG_ADR0) return SIG0;
      if (x == `EPRVP_SIG_ADR1) return SIG1;
      if (x == `EPRVP_SIG_ADR2) return SIG2;
      return 8'hFF;
    end
    if (lk[1]) return 8'hFF;
    return ~(mem[x[7:0]] ^ tab[x[5:0]]);
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, gt);
    n_compared++;
    if (gt !== ex) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, ex, gt);
    end
  endtask

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Erase clears code, table and locks
  task automatic erase;
    int k;
    apb(1'b1, `EPRVP_OFF_CTRL, 32'h0000_0003);
    k = 0;
    do begin
      apb(1'b0, `EPRVP_OFF_STATUS, 32'h0);
      k++;
    end while (q[`EPRVP_ST_BUSY] !== 1'b0 && k < 200);
    chk("erase busy", 32'h0, {31'h0, q[`EPRVP_ST_BUSY]});
    foreach (mem[j]) mem[j] = 8'hFF;
    foreach (tab[j]) tab[j] = 8'hFF;
    lk = 3'b000;
  endtask

  // Program through the pins and track what should stick
  task automatic prg(input logic [4:0] p, input logic [13:0] x,
                     input logic [7:0] dv, input int n, input logic v);
    eprvp_prog_model_i.prog(p, x, dv, n, v);
    if (v && !lk[0] && p == `EPRVP_PAT_PROG) mem[x[7:0]] &= dv;
    if (v && !lk[0] && p == `EPRVP_PAT_CRYPT) tab[x[5:0]] &= dv;
    if (v && p == `EPRVP_PAT_LOCK1) lk[0] = 1'b1;
    if (v && p == `EPRVP_PAT_LOCK2) lk[1] = 1'b1;
    if (v && p == `EPRVP_PAT_LOCK3) lk[2] = 1'b1;
    chk("oe while programming", 32'h0, {31'h0, oe});
  endtask

  task automatic vfy(input logic [4:0] p, input logic [13:0] x);
    eprvp_prog_model_i.rd_byte(p, x, d, e);
    chk("read byte", {24'h0, exp_rd(p, x)}, {24'h0, d});
    chk("oe while reading", 32'h1, {31'h0, e});
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    seed = 32'h7feab8ae;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("prot", 32'h0, {28'h0, oe, trb, eaa, xeb});
    apb(1'b0, `EPRVP_OFF_CTRL, 32'h0);
    chk("ctrl", 32'h2, q);
    chk("ctrl err", 32'h0, {31'h0, e});
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    erase();
    for (i = 0; i < 12; i++) begin
      seed = xs(seed);
      a = {6'h00, seed[7:0]};
      prg(`EPRVP_PAT_PROG, a, seed[15:8], 5, 1'b1);
      if (i % 3 == 0) prg(`EPRVP_PAT_PROG, a, seed[23:16], 5, 1'b1);
      vfy(`EPRVP_PAT_VERIFY, a);
    end
    apb(1'b0, `EPRVP_OFF_LASTADR, 32'h0);
    chk("last address", {18'h0, a}, q);
    prg(`EPRVP_PAT_PROG, a, 8'h00, 5, 1'b0);
    prg(5'h15, a, 8'h00, 5, 1'b1);
    vfy(`EPRVP_PAT_VERIFY, a);
    vfy(`EPRVP_PAT_SIG, `EPRVP_SIG_ADR0);
    vfy(`EPRVP_PAT_SIG, `EPRVP_SIG_ADR1);
    vfy(`EPRVP_PAT_SIG, `EPRVP_SIG_ADR2);
    vfy(`EPRVP_PAT_SIG, 14'h0012);
    prg(`EPRVP_PAT_CRYPT, a, seed[31:24], 25, 1'b1);
    vfy(`EPRVP_PAT_VERIFY, a);
    vfy(`EPRVP_PAT_VERIFY, a ^ 14'h0040);
    eprvp_prog_model_i.pulse_reset();
    chk("ea unlatched", 32'h0, {31'h0, eal});
    prg(`EPRVP_PAT_LOCK1, a, 8'h00, 25, 1'b1);
    chk("lock one", 32'h6, {29'h0, trb, eaa, xeb});
    eprvp_prog_model_i.pulse_reset();
    chk("ea latched", 32'h1, {31'h0, eal});
    prg(`EPRVP_PAT_PROG, a, 8'h00, 5, 1'b1);
    prg(`EPRVP_PAT_CRYPT, a, 8'h00, 25, 1'b1);
    vfy(`EPRVP_PAT_VERIFY, a);
    prg(`EPRVP_PAT_LOCK2, a, 8'h00, 25, 1'b1);
    vfy(`EPRVP_PAT_VERIFY, a);
    chk("lock two", 32'h6, {29'h0, trb, eaa, xeb});
    prg(`EPRVP_PAT_LOCK3, a, 8'h00, 25, 1'b1);
    chk("lock three", 32'h7, {29'h0, trb, eaa, xeb});
    vfy(`EPRVP_PAT_SIG, `EPRVP_SIG_ADR1);
    erase();
    chk("erased prot", 32'h0, {29'h0, trb, eaa, xeb});
    vfy(`EPRVP_PAT_VERIFY, a);
    end_of_test();
  end

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
endmodule  // eprvp_port_tb
